// >>> verilog/epr_consts.vh
// Purpose: Constants for the ECC-protected program memory.
// Assumes: 512 x 72 array, three 18-bit instructions per word.
// Notes:   Included by both design files.
`ifndef EPR_CONSTS_VH
`define EPR_CONSTS_VH
`define EPR_DEPTH      512
`define EPR_AW         9
`define EPR_DATA_W     64
`define EPR_CHK_W      8
`define EPR_WORD_W     72
`define EPR_INS_W      18
`define EPR_SLOT_LIMIT 3'h3
`define EPR_INS_RESET  18'h00000
`define EPR_SLOT0_LSB  0
`define EPR_SLOT1_LSB  19
`define EPR_SLOT2_LSB  38
`endif

// >>> verilog/epr_mem.v
// Purpose: 512 x 72 read-only array with registered read data.
// Assumes: Contents preloaded from a parameter-free initial image.
// Notes:   No write port, so correction can never reach the array.
`timescale 1ns/1ps
`include "epr_consts.vh"
module epr_mem #(
	parameter DEPTH = `EPR_DEPTH,
	parameter AW    = `EPR_AW,
	parameter W     = `EPR_WORD_W
) (
	input  wire          sys_clk,
	input  wire          rd_en,
	input  wire [AW-1:0] rd_addr,
	output reg  [W-1:0]  rd_data_ff
);
	// Storage; a build flow fills it by hierarchical init
	reg [W-1:0] mem [0:DEPTH-1];
	integer i;

	// Blank image: all-zero words are valid codewords
	initial begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			mem[i] = {W{1'b0}};
		end
	end

	// Read only on an enabled edge, no write path at all
	always @(posedge sys_clk) begin
		if (rd_en) begin
			rd_data_ff <= mem[rd_addr];
		end
	end
endmodule

// >>> verilog/epr_rom.v
// Purpose: ECC-protected program ROM: fetch, check, correct, select.
// Assumes: Hsiao-style SEC-DED over 64 data bits with 8 check bits.
// Notes:   Decode is combinational on the array register; outputs are flopped.
`timescale 1ns/1ps
`include "epr_consts.vh"
module epr_rom #(
	parameter [17:0] FALLBACK_INS = 18'h00000, // Fallback jump, zero means none
	parameter        USE_FALLBACK = 0
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        enable,
	input  wire [11:0] address,
	output reg  [17:0] instruction_ff,
	output reg         single_error_flag_ff,
	output reg         double_error_flag_ff
);
	////////////////////////////////////////////////////////////////////////
	// Check matrix: column j of data bit j; unique odd weight for SEC-DED
	// Column code is bit index + chosen odd-weight pattern generator
	function [7:0] col_code;
		input integer j;
		reg [7:0] c;
		integer k, n, w;
		begin
			c = 8'h00;
			n = -1;
			// Walk 8-bit values, keep weight 3 and 5, take the j-th
			for (k = 0; k < 256; k = k + 1) begin
				w = k[0] + k[1] + k[2] + k[3] + k[4] + k[5] + k[6] + k[7];
				if ((w == 3 || w == 5) && n < j) begin
					n = n + 1;
					c = k[7:0];
				end
			end
			col_code = c;
		end
	endfunction

	// Syndrome from data and stored check bits
	function [7:0] syndrome;
		input [63:0] d;
		input [7:0]  chk;
		reg   [7:0]  s;
		integer j;
		begin
			s = chk;
			for (j = 0; j < 64; j = j + 1) begin
				if (d[j]) begin
					s = s ^ col_code(j);
				end
			end
			syndrome = s;
		end
	endfunction

	// Number of one bits in a syndrome
	function [3:0] pop8;
		input [7:0] v;
		begin
			pop8 = {3'h0, v[0]} + {3'h0, v[1]} + {3'h0, v[2]} + {3'h0, v[3]}
			     + {3'h0, v[4]} + {3'h0, v[5]} + {3'h0, v[6]} + {3'h0, v[7]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Array and fetch control
	wire [`EPR_WORD_W-1:0] raw_word;     // Registered array output
	reg  [2:0]             slot_ff;      // Instruction slot of this read
	reg                    rd_pend_ff;   // A word was read last edge

	// Word index is address[8:0]; slot is address[11:9]
	epr_mem u_mem (
		.sys_clk    (sys_clk),
		.rd_en      (enable),
		.rd_addr    (address[8:0]),
		.rd_data_ff (raw_word)
	);

	// Remember slot and that a fresh word arrives next cycle
	always @(posedge sys_clk) begin
		if (reset) begin
			slot_ff    <= 3'h0;
			rd_pend_ff <= 1'b0;
		end else begin
			rd_pend_ff <= enable;
			if (enable) begin
				slot_ff <= address[11:9];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decode: data [63:0], check [71:64]; 10 unused bits in data field
	// Slots sit in contiguous fields with a spare bit between them, so an
	// adjacent two-bit upset can never straddle two instructions
	wire [63:0] data_raw = raw_word[63:0];
	wire [7:0]  chk_raw  = raw_word[71:64];
	wire [7:0]  syn      = syndrome(data_raw, chk_raw);
	wire [3:0]  syn_w    = pop8(syn);
	wire        err_any  = (syn != 8'h00);
	// Odd weight means one flipped bit, even nonzero means two
	wire        err_one  = err_any & syn_w[0];
	wire        err_two  = err_any & ~syn_w[0];

	reg  [63:0] data_fix;
	integer     b;

	// Flip the data bit whose column matches; check-bit errors need nothing
	always @* begin
		data_fix = data_raw;
		for (b = 0; b < 64; b = b + 1) begin
			if (err_one && syn == col_code(b)) begin
				data_fix[b] = ~data_raw[b];
			end
		end
	end

	// Slot 0 at [17:0], slot 1 at [36:19], slot 2 at [55:38]; bits 18, 37
	// and [63:56] stay unused. Word n holds n, n+200h, n+400h
	reg [17:0] ins_sel;
	integer    i;
	always @* begin
		ins_sel = `EPR_INS_RESET;
		for (i = 0; i < 18; i = i + 1) begin
			case (slot_ff)
				3'h0:    ins_sel[i] = data_fix[`EPR_SLOT0_LSB + i];
				3'h1:    ins_sel[i] = data_fix[`EPR_SLOT1_LSB + i];
				3'h2:    ins_sel[i] = data_fix[`EPR_SLOT2_LSB + i];
				default: ins_sel[i] = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output registers: refresh only after an enabled read, else hold
	always @(posedge sys_clk) begin
		if (reset) begin
			instruction_ff       <= `EPR_INS_RESET;
			single_error_flag_ff <= 1'b0;
			double_error_flag_ff <= 1'b0;
		end else if (rd_pend_ff) begin
			if (slot_ff >= `EPR_SLOT_LIMIT) begin
				// Out of range: zero or fallback, no memory content
				instruction_ff <= USE_FALLBACK ? FALLBACK_INS : `EPR_INS_RESET;
			end else begin
				instruction_ff <= ins_sel;
			end
			// Flags follow the word actually read, every time
			single_error_flag_ff <= err_one;
			double_error_flag_ff <= err_two;
		end
	end
endmodule

// >>> verification/epr_monitor.sv
// Purpose: Port checks for epr_rom
// Assumes: Zero instruction above 5FF
// Notes: Results land two edges after a read
`timescale 1ns/1ps
module epr_monitor (
	input wire        sys_clk,
	input wire        reset,
	input wire        enable,
	input wire [11:0] address,
	input wire [17:0] instruction_ff,
	input wire        single_error_flag_ff,
	input wire        double_error_flag_ff
);
	wire [19:0] o = {instruction_ff, single_error_flag_ff, double_error_flag_ff};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence idle_s; !enable ##1 !enable; endsequence
	sequence again_s; enable && $past(enable) && !$past(reset) && $stable(address); endsequence
	idle_hold_a: assert property (idle_s |=> $stable(o)) else $error("hold");
	reread_same_a: assert property (again_s |-> ##2 $stable(o)) else $error("reread");
	high_zero_a: assert property (enable && address > 12'h5ff |-> ##2 !instruction_ff)
		else $error("range");
	flag_excl_a: assert property (!(single_error_flag_ff && double_error_flag_ff))
		else $error("both");
	sgl_cause_a: assert property ($rose(single_error_flag_ff) |-> $past(enable, 2))
		else $error("sgl");
	dbl_cause_a: assert property ($rose(double_error_flag_ff) |-> $past(enable, 2))
		else $error("dbl");
	ins_cause_a: assert property ($changed(instruction_ff) |-> $past(enable, 2))
		else $error("ins");
	reset_clear_a: assert property (disable iff (1'b0) reset |=> o == 20'h0)
		else $error("rst");
endmodule
bind epr_rom epr_monitor i_epr_monitor (.sys_clk(sys_clk), .reset(reset), .enable(enable),
	.address(address), .instruction_ff(instruction_ff),
	.single_error_flag_ff(single_error_flag_ff), .double_error_flag_ff(double_error_flag_ff));

// >>> verification/epr_cpu_log.sv
// Purpose: Fetch-side logger of single-bit reports
// Assumes: Flag sampled each edge
// Notes: Repeats of one faulty word are ignored
`timescale 1ns/1ps
module epr_cpu_log (
	input  wire sys_clk,
	input  wire reset,
	input  wire single_error_flag_ff,
	output reg  logged_ff
);
	// Keep only the first report
	always @(posedge sys_clk) begin
		if (reset) logged_ff <= 1'b0;
		else if (single_error_flag_ff) logged_ff <= 1'b1;
	end
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for epr_rom
// Assumes: Array preloaded through u_mem.mem
// Notes: Inputs move on falling edges
`timescale 1ns/1ps
`define CHK(n,e,s) begin n_checks++; if ((s) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
	reg         sys_clk = 0;
	reg         reset   = 1;
	reg         enable  = 0;
	reg  [11:0] address = 12'h0;
	wire [17:0] ins;
	wire        s_err;
	wire        d_err;
	wire        logged;
	reg  [17:0] ex [0:2];
	reg  [71:0] w;
	integer     fails = 0;
	integer     n_checks = 0;
	integer     s;
	integer     nd;
	always #2.5 sys_clk = ~sys_clk;
	epr_rom i_epr_rom (.sys_clk(sys_clk), .reset(reset), .enable(enable), .address(address),
		.instruction_ff(ins), .single_error_flag_ff(s_err), .double_error_flag_ff(d_err));
	epr_cpu_log i_epr_cpu_log (.sys_clk(sys_clk), .reset(reset),
		.single_error_flag_ff(s_err), .logged_ff(logged));
	////////////////////////////////////////
	function [7:0] ck(input [63:0] d);
		integer v;
		integer j;
		begin
			ck = 8'h0;
			j = 0;
			for (v = 0; v < 256; v++) if ($countones(v[7:0]) inside {3, 5} && j < 64) begin
				if (d[j]) ck = ck ^ v[7:0];
				j++;
			end
		end
	endfunction
	function [71:0] wd(input [17:0] a, input [17:0] b, input [17:0] c);
		reg [63:0] d;
		integer i;
		begin
			d = 64'h0;
			for (i = 0; i < 18; i++) begin
				d[i] = a[i];
				d[19+i] = b[i];
				d[38+i] = c[i];
			end
			wd = {ck(d), d};
		end
	endfunction
	// Hold enable for n reads, then wait out the two-edge latency
	task rd(input [11:0] a, input integer n); begin
		@(negedge sys_clk) enable = 1;
		address = a;
		repeat (n) @(negedge sys_clk);
		enable = 0;
		repeat (2) @(negedge sys_clk);
	end endtask
	task t_clean; begin
		for (s = 0; s < 3; s++) begin
			rd(12'h005 + 12'h200 * s[11:0], 1);
			`CHK("ins", ex[s], ins)
			`CHK("flags", 2'b00, {s_err, d_err})
		end
		$display("clean done");
	end endtask
	task t_single; begin
		i_epr_rom.u_mem.mem[5] = w ^ (72'h1 << 7);
		rd(12'h005, 2);
		`CHK("fix", ex[0], ins)
		`CHK("flags", 2'b10, {s_err, d_err})
		rd(12'h205, 1);
		`CHK("again", 1'b1, s_err)
		`CHK("log", 1'b1, logged)
		`CHK("kept", w ^ (72'h1 << 7), i_epr_rom.u_mem.mem[5])
		$display("single done");
	end endtask
	task t_double; begin
		i_epr_rom.u_mem.mem[5] = w ^ (72'h3 << 9);
		nd = 0;
		for (s = 0; s < 3; s++) begin
			rd(12'h005 + 12'h200 * s[11:0], 1);
			`CHK("flags", 2'b01, {s_err, d_err})
			if (ins !== ex[s]) nd++;
		end
		`CHK("hit", 1'b1, nd == 1)
		$display("double done");
	end endtask
	task t_range; begin
		for (s = 0; s < 3; s++) begin
			rd(12'h600 + 12'h4ff * s[11:0], 1);
			`CHK("zero", 18'h0, ins)
		end
		@(negedge sys_clk) address = 12'h205;
		repeat (4) @(negedge sys_clk);
		`CHK("idle", 20'h0, {ins, s_err, d_err})
		$display("range done");
	end endtask
	task stop_test; begin
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	end endtask
	initial begin
		ex[0] = 18'h2a5a5;
		ex[1] = 18'h15a5a;
		ex[2] = 18'h3c3c3;
		repeat (3) @(negedge sys_clk);
		reset = 0;
		w = wd(ex[0], ex[1], ex[2]);
		i_epr_rom.u_mem.mem[5] = w;
		t_clean;
		t_single;
		t_double;
		t_range;
		stop_test;
	end
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule
